/* File: shared/bdc_pkg.sv */
// Constants and types shared by the bridge control register bank.
package bdc_pkg;
    // ========================================================
    // Register offsets (byte addresses in configuration space)
    localparam logic [7:0]  BDC_ID_OFS     = 8'h00;
    localparam logic [7:0]  BDC_DEVCTL_OFS = 8'h92;
    localparam logic [7:0]  BDC_DIAGNOSTIC_FIELD_OFS   = 8'h93;
    localparam logic [7:0]  BDC_DMA_OFS    = 8'h94;
    // ========================================================
    // Device control field positions
    localparam int DC_PWR_LOCK = 7;
    localparam int DC_LV_CAP   = 6;
    localparam int DC_DIAGNOSTIC_FIELD_IO  = 5;
    localparam int DC_RSVD     = 4;
    localparam int DC_TEST     = 3;
    localparam int DC_IRQ_LO   = 1;
    localparam int DC_NAND     = 0;
    // Diagnostic field positions
    localparam int DG_ID_MASK  = 7;
    localparam int DG_CSC_RT   = 5;
    localparam int DG_DT_DIS   = 4;
    localparam int DG_RTY_EXT  = 3;
    localparam int DG_CB_DISC  = 2;
    localparam int DG_HB_DISC  = 1;
    localparam int DG_ASYNC    = 0;
    // ========================================================
    // Reset values and write masks
    localparam logic [7:0]  BDC_DEVCTL_RST = 8'h66;
    localparam logic [7:0]  BDC_DIAGNOSTIC_FIELD_RST   = 8'h61;
    localparam logic [1:0]  BDC_DMA_RST    = 2'h0;
    localparam logic [7:0]  BDC_DEVCTL_WM  = 8'hEF;
    // Arbitrary identity value, chosen only to be recognisable.
    localparam logic [31:0] BDC_ID_DEFAULT = 32'h5A5A_1234;
    // ========================================================
    // Encodings
    localparam logic [1:0]  IRQ_PAR_ONLY   = 2'h0;
    localparam logic [1:0]  IRQ_RESERVED   = 2'h1;
    localparam logic [1:0]  IRQ_SER_PAR    = 2'h2;
    localparam logic [1:0]  IRQ_SER_ALL    = 2'h3;
    localparam logic [1:0]  DMA_PIN_NONE   = 2'h0;
    localparam logic [1:0]  DMA_PIN_SPKR   = 2'h1;
    localparam logic [1:0]  DMA_PIN_IO16   = 2'h2;
    localparam logic [1:0]  DMA_PIN_INACK  = 2'h3;
    localparam logic [3:0]  BDC_RT805_VAL  = 4'h0;
    // ========================================================
    // Timing counts in clocks
    localparam logic [7:0]  RETRY_LAT_STD  = 8'h10;
    localparam logic [7:0]  RETRY_LAT_EXT  = 8'h40;
    localparam int          DISC_EXP_SHORT = 10;
    localparam int          DISC_EXP_LONG  = 15;
    localparam logic [15:0] DISC_SHORT = 16'(1 << DISC_EXP_SHORT);
    localparam logic [15:0] DISC_LONG  = 16'(1 << DISC_EXP_LONG);
    // ========================================================
    // Register bank state
    typedef struct packed {
        logic [7:0]       devctl;
        logic [7:0]       diagnostic_field;
        logic [1:0][1:0]  dma_pin;
        logic [31:0]      rdata;
        logic             ack;
    } bdc_state_t;
    localparam bdc_state_t BDC_STATE_RST = '{
        devctl:  BDC_DEVCTL_RST,
        diagnostic_field:    BDC_DIAGNOSTIC_FIELD_RST,
        dma_pin: {BDC_DMA_RST, BDC_DMA_RST},
        rdata:   32'h0000_0000,
        ack:     1'b0
    };
endpackage

/* File: shared/bdc_ctl_if.sv */
// Carries the stored control fields from the register bank to its decoder.
`timescale 1ns/1ps
interface bdc_ctl_if;
    logic [7:0]       devctl;
    logic [7:0]       diagnostic_field;
    logic [1:0][1:0]  dma_pin;
    modport src (output devctl, output diagnostic_field, output dma_pin);
    modport dst (input devctl, input diagnostic_field, input dma_pin);
endinterface

/* File: rtl/bdc_ctl_decode.sv */
// Turns stored control fields into the block's steering outputs.
`timescale 1ns/1ps
module bdc_ctl_decode (
    bdc_ctl_if.dst                ctl,
    input  wire logic [1:0]       pwr_down_req_in,
    input  wire logic [1:0]       d3_state_in,
    input  wire logic [1:0]       legacy_csc_en_in,
    input  wire logic [1:0][3:0]  legacy_csc_sel_in,
    output logic      [1:0]       socket_power_down_out,
    output logic                  low_voltage_capable_out,
    output logic                  diagnostic_field_io_bit_out,
    output logic                  interrog_short_out,
    output logic      [1:0]       irq_signalling_select_out,
    output logic                  nand_tree_en_out,
    output logic      [1:0]       card_status_change_route_out,
    output logic                  delayed_txn_disable_out,
    output logic      [7:0]       retry_latency_limit_out,
    output logic      [15:0]      card_bus_discard_limit_out,
    output logic      [15:0]      host_bus_discard_limit_out,
    output logic                  async_status_change_irq_out,
    output logic      [1:0]       dma_req_speaker_out,
    output logic      [1:0]       dma_req_io16_out,
    output logic      [1:0]       dma_req_inack_out
);
    import bdc_pkg::*;

    // ========================================================
    // Global controls
    assign low_voltage_capable_out = ctl.devctl[DC_LV_CAP];     // see RULE_02
    assign diagnostic_field_io_bit_out         = ctl.devctl[DC_DIAGNOSTIC_FIELD_IO];    // see RULE_03
    assign interrog_short_out      = ctl.devctl[DC_TEST];       // see RULE_05
    assign irq_signalling_select_out =
        ctl.devctl[DC_IRQ_LO +: 2];                             // see RULE_06
    // The chain itself covers only input and two-way pins.
    assign nand_tree_en_out        = ctl.devctl[DC_NAND];       // see RULE_07
    assign delayed_txn_disable_out = ctl.diagnostic_field[DG_DT_DIS];       // see RULE_11
    assign retry_latency_limit_out = ctl.diagnostic_field[DG_RTY_EXT] ?
        RETRY_LAT_EXT : RETRY_LAT_STD;                          // see RULE_12
    assign card_bus_discard_limit_out = ctl.diagnostic_field[DG_CB_DISC] ?
        DISC_SHORT : DISC_LONG;                                 // see RULE_13
    assign host_bus_discard_limit_out = ctl.diagnostic_field[DG_HB_DISC] ?
        DISC_SHORT : DISC_LONG;                                 // see RULE_14
    assign async_status_change_irq_out = ctl.diagnostic_field[DG_ASYNC];    // see RULE_15

    // ========================================================
    // Per-socket controls
    for (genvar f = 0; f < 2; f++) begin : g_sock
        // A locked socket stays powered while its function is in D3.
        assign socket_power_down_out[f] = pwr_down_req_in[f] &
            ~(ctl.devctl[DC_PWR_LOCK] & d3_state_in[f]);        // see RULE_01
        assign card_status_change_route_out[f] = ctl.diagnostic_field[DG_CSC_RT] ?
            (legacy_csc_sel_in[f] == BDC_RT805_VAL) :
            legacy_csc_en_in[f];                                // see RULE_10
        assign dma_req_speaker_out[f] =
            (ctl.dma_pin[f] == DMA_PIN_SPKR);                   // see RULE_17
        assign dma_req_io16_out[f]  = (ctl.dma_pin[f] == DMA_PIN_IO16);
        assign dma_req_inack_out[f] = (ctl.dma_pin[f] == DMA_PIN_INACK);
    end
endmodule // bdc_ctl_decode

/* File: rtl/bdc_regs.sv */
// Bridge device, diagnostic and socket DMA control register bank.
//
// Functional notes
// RULE_01 - Power lock set: socket power-down ignored while function in D3.
// RULE_02 - Device control bit 6 forces 3-V capable report; resets to 1.
// RULE_03 - Device control bit 5 is a read/write diagnostic bit, reset 1.
// RULE_04 - Device control bit 4 reads zero; writes to it do nothing.
// RULE_05 - Software writes 0 to bit 3; set shortens interrogation counter.
// RULE_06 - Bits 2-1 select interrupt mode; 00,01 rsvd,10,11 reset value.
// RULE_07 - Bit 0 enables the NAND-tree chain over input and two-way pins.
// RULE_08 - Software should reach shared global bits only via function 0.
// RULE_09 - Diagnostic bit 7 set makes identifier reads return all ones.
// RULE_10 - Diagnostic bit 5 selects status-change routing source; reset 1.
// RULE_11 - Diagnostic bit 4 disables delayed-transaction handling.
// RULE_12 - Diagnostic bit 3 extends retry latency limit from 16 to 64.
// RULE_13 - Diagnostic bit 2 picks card-side discard timer 2^10 or 2^15.
// RULE_14 - Diagnostic bit 1 picks host-side discard timer 2^10 or 2^15.
// RULE_15 - Diagnostic bit 0 enables asynchronous status-change irq; reset 1.
// RULE_16 - Socket DMA register: bits 31-2 read zero, bits 1-0 R/W, reset 0.
// RULE_17 - DMA pin field: 00 none, 01 speaker, 10 io16, 11 input ack.
// RULE_18 - Host bus reset returns every field to its default value.
`timescale 1ns/1ps
module bdc_regs #(
    parameter logic [31:0] ID_VALUE = bdc_pkg::BDC_ID_DEFAULT
) (
    input  wire logic             core_clk_in,
    input  wire logic             rstn_in,
    input  wire logic             cfg_func_in,
    input  wire logic [5:0]       cfg_dw_in,
    input  wire logic [3:0]       cfg_be_in,
    input  wire logic             cfg_wr_in,
    input  wire logic             cfg_rd_in,
    input  wire logic [31:0]      cfg_wdata_in,
    output logic      [31:0]      cfg_rdata_out,
    output logic                  cfg_ack_out,
    input  wire logic [1:0]       pwr_down_req_in,
    input  wire logic [1:0]       d3_state_in,
    input  wire logic [1:0]       legacy_csc_en_in,
    input  wire logic [1:0][3:0]  legacy_csc_sel_in,
    output logic      [1:0]       socket_power_down_out,
    output logic                  low_voltage_capable_out,
    output logic                  diagnostic_field_io_bit_out,
    output logic                  interrog_short_out,
    output logic      [1:0]       irq_signalling_select_out,
    output logic                  nand_tree_en_out,
    output logic      [1:0]       card_status_change_route_out,
    output logic                  delayed_txn_disable_out,
    output logic      [7:0]       retry_latency_limit_out,
    output logic      [15:0]      card_bus_discard_limit_out,
    output logic      [15:0]      host_bus_discard_limit_out,
    output logic                  async_status_change_irq_out,
    output logic      [1:0]       dma_req_speaker_out,
    output logic      [1:0]       dma_req_io16_out,
    output logic      [1:0]       dma_req_inack_out
);
    import bdc_pkg::*;

    // ========================================================
    // Address decode
    localparam logic [5:0] DW_ID   = BDC_ID_OFS[7:2];
    localparam logic [5:0] DW_CTL  = BDC_DEVCTL_OFS[7:2];
    localparam logic [5:0] DW_DMA  = BDC_DMA_OFS[7:2];
    localparam int         LN_DC   = int'(BDC_DEVCTL_OFS[1:0]);
    localparam int         LN_DG   = int'(BDC_DIAGNOSTIC_FIELD_OFS[1:0]);
    localparam int         LN_DMA  = int'(BDC_DMA_OFS[1:0]);

    bdc_state_t  st_reg;
    bdc_state_t  st_next;
    logic [31:0] rd_word;
    logic        hit_id;
    logic        hit_ctl;
    logic        hit_dma;

    assign hit_id  = (cfg_dw_in == DW_ID);
    assign hit_ctl = (cfg_dw_in == DW_CTL);
    assign hit_dma = (cfg_dw_in == DW_DMA);

    // ========================================================
    // Read data
    // Bytes of the control dword that belong to other blocks read zero.
    always_comb begin
        rd_word = 32'h0000_0000;
        if (hit_id) begin
            rd_word = st_reg.diagnostic_field[DG_ID_MASK] ?
                32'hFFFF_FFFF : ID_VALUE;                       // see RULE_09
        end else if (hit_ctl) begin
            rd_word[LN_DC*8 +: 8] = st_reg.devctl;
            rd_word[LN_DG*8 +: 8] = st_reg.diagnostic_field;
        end else if (hit_dma) begin
            rd_word[LN_DMA*8 +: 2] = st_reg.dma_pin[cfg_func_in]; // see RULE_16
        end
    end

    // ========================================================
    // Next state
    // Both functions write the same shared bytes; keeping them consistent
    // is left to software using function 0.
    always_comb begin
        st_next     = st_reg;
        st_next.ack = cfg_wr_in | cfg_rd_in;
        if (cfg_wr_in && hit_ctl) begin
            if (cfg_be_in[LN_DC]) begin
                st_next.devctl = cfg_wdata_in[LN_DC*8 +: 8] &
                    BDC_DEVCTL_WM;                              // see RULE_04
            end
            if (cfg_be_in[LN_DG]) begin
                st_next.diagnostic_field = cfg_wdata_in[LN_DG*8 +: 8];
            end
        end
        if (cfg_wr_in && hit_dma && cfg_be_in[LN_DMA]) begin
            st_next.dma_pin[cfg_func_in] =
                cfg_wdata_in[LN_DMA*8 +: 2];                    // see RULE_16
        end
        if (cfg_rd_in) begin
            st_next.rdata = rd_word;
        end
        if (!rstn_in) begin
            st_next = BDC_STATE_RST;                            // see RULE_18
        end
    end

    always_ff @(posedge core_clk_in) begin
        st_reg <= st_next;
    end

    assign cfg_rdata_out = st_reg.rdata;
    assign cfg_ack_out   = st_reg.ack;

    // ========================================================
    // Field decode
    bdc_ctl_if ctl ();

    assign ctl.devctl  = st_reg.devctl;
    assign ctl.diagnostic_field    = st_reg.diagnostic_field;
    assign ctl.dma_pin = st_reg.dma_pin;

    bdc_ctl_decode u_decode (
        .ctl                          (ctl),
        .pwr_down_req_in              (pwr_down_req_in),
        .d3_state_in                  (d3_state_in),
        .legacy_csc_en_in             (legacy_csc_en_in),
        .legacy_csc_sel_in            (legacy_csc_sel_in),
        .socket_power_down_out        (socket_power_down_out),
        .low_voltage_capable_out      (low_voltage_capable_out),
        .diagnostic_field_io_bit_out              (diagnostic_field_io_bit_out),
        .interrog_short_out           (interrog_short_out),
        .irq_signalling_select_out    (irq_signalling_select_out),
        .nand_tree_en_out             (nand_tree_en_out),
        .card_status_change_route_out (card_status_change_route_out),
        .delayed_txn_disable_out      (delayed_txn_disable_out),
        .retry_latency_limit_out      (retry_latency_limit_out),
        .card_bus_discard_limit_out   (card_bus_discard_limit_out),
        .host_bus_discard_limit_out   (host_bus_discard_limit_out),
        .async_status_change_irq_out  (async_status_change_irq_out),
        .dma_req_speaker_out          (dma_req_speaker_out),
        .dma_req_io16_out             (dma_req_io16_out),
        .dma_req_inack_out            (dma_req_inack_out)
    );

    // ========================================================
    // Assertions
    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!rstn_in);

    sequence s_ctl_wr_dc;
        cfg_wr_in && hit_ctl && cfg_be_in[LN_DC];
    endsequence

    sequence s_ctl_wr_dg;
        cfg_wr_in && hit_ctl && cfg_be_in[LN_DG];
    endsequence

    sequence s_ctl_rd;
        cfg_rd_in && hit_ctl;
    endsequence

    sequence s_id_rd;
        cfg_rd_in && hit_id;
    endsequence

    sequence s_dma_wr;
        cfg_wr_in && hit_dma && cfg_be_in[LN_DMA] && !cfg_rd_in;
    endsequence

    a_reset_defaults: assert property (                         // see RULE_18
        !$past(rstn_in) |->
            st_reg.devctl == BDC_DEVCTL_RST &&
            st_reg.diagnostic_field == BDC_DIAGNOSTIC_FIELD_RST &&
            st_reg.dma_pin == {BDC_DMA_RST, BDC_DMA_RST})
        else $error("Fields differ from defaults after reset.");

    a_power_lock: assert property (                             // see RULE_01
        (st_reg.devctl[DC_PWR_LOCK] && d3_state_in[0]) |->
            !socket_power_down_out[0])
        else $error("Locked socket powered down in D3.");

    a_devctl_write: assert property (                           // see RULE_03
        s_ctl_wr_dc |=> st_reg.devctl ==
            ($past(cfg_wdata_in[LN_DC*8 +: 8]) & BDC_DEVCTL_WM))
        else $error("Device control write not stored.");

    a_rsvd_reads_zero: assert property (                        // see RULE_04
        s_ctl_rd |=> cfg_ack_out && !cfg_rdata_out[LN_DC*8+DC_RSVD])
        else $error("Reserved device control bit read as one.");

    a_irq_mode_out: assert property (                           // see RULE_06
        s_ctl_wr_dc |=> irq_signalling_select_out ==
            $past(cfg_wdata_in[LN_DC*8+DC_IRQ_LO +: 2]))
        else $error("Interrupt mode output does not follow write.");

    a_id_masked: assert property (                              // see RULE_09
        s_id_rd and st_reg.diagnostic_field[DG_ID_MASK] |=>
            cfg_rdata_out == 32'hFFFF_FFFF)
        else $error("Identifier read not masked to all ones.");

    a_id_true: assert property (                                // see RULE_09
        s_id_rd and !st_reg.diagnostic_field[DG_ID_MASK] |=> cfg_rdata_out == ID_VALUE)
        else $error("Identifier read does not return true value.");

    a_csc_routing: assert property (                            // see RULE_10
        st_reg.diagnostic_field[DG_CSC_RT] |-> card_status_change_route_out[1] ==
            (legacy_csc_sel_in[1] == BDC_RT805_VAL))
        else $error("Status-change routing ignores selected source.");

    a_retry_limit: assert property (                            // see RULE_12
        s_ctl_wr_dg ##1 st_reg.diagnostic_field[DG_RTY_EXT] |->
            retry_latency_limit_out == RETRY_LAT_EXT)
        else $error("Extended retry limit not 64.");

    a_discard_sel: assert property (                            // see RULE_13
        s_ctl_wr_dg |=> card_bus_discard_limit_out ==
            ($past(cfg_wdata_in[LN_DG*8+DG_CB_DISC]) ?
                DISC_SHORT : DISC_LONG))
        else $error("Card-side discard limit wrong.");

    a_host_discard: assert property (                           // see RULE_14
        s_ctl_wr_dg |=> host_bus_discard_limit_out ==
            ($past(cfg_wdata_in[LN_DG*8+DG_HB_DISC]) ?
                DISC_SHORT : DISC_LONG))
        else $error("Host-side discard limit wrong.");

    a_dma_write_read: assert property (                         // see RULE_16
        s_dma_wr ##1 !cfg_wr_in ##1 (cfg_rd_in && hit_dma &&
            cfg_func_in == $past(cfg_func_in, 2)) |=>
            cfg_rdata_out == {30'h0, $past(cfg_wdata_in[1:0], 3)})
        else $error("Socket DMA readback wrong.");

    a_dma_pin_decode: assert property (                         // see RULE_17
        st_reg.dma_pin[0] == DMA_PIN_NONE |->
            !(dma_req_speaker_out[0] || dma_req_io16_out[0] ||
              dma_req_inack_out[0]))
        else $error("Unconfigured socket selects a request pin.");

    a_ack_pulse: assert property (
        !(cfg_wr_in || cfg_rd_in) |=> !cfg_ack_out)
        else $error("Acknowledge without request.");
endmodule // bdc_regs

/* File: dv/bdc_host_model.sv */
// Host configuration master model that issues single accesses to the bank.
`timescale 1ns/1ps
module bdc_host_model (
    input  wire logic        clk_in,
    input  wire logic        ack_in,
    input  wire logic [31:0] rdata_in,
    output logic             func_out,
    output logic [5:0]       dw_out,
    output logic [3:0]       be_out,
    output logic             wr_out,
    output logic             rd_out,
    output logic [31:0]      wdata_out
);
    initial begin
        func_out  = 1'h0;
        dw_out    = 6'h00;
        be_out    = 4'h0;
        wr_out    = 1'h0;
        rd_out    = 1'h0;
        wdata_out = 32'h0000_0000;
    end

    // ========================================================
    // Access
    // The strobe stands for one cycle; the answer is taken one cycle later.
    // Stale write data is inverted so a lost lane cannot pass by chance.
    task automatic access(input logic w, input logic f,
                          input logic [5:0] dw, input logic [3:0] be,
                          input logic [31:0] d,
                          output logic ack, output logic [31:0] q);
        @(posedge clk_in);
        func_out  <= f;
        dw_out    <= dw;
        be_out    <= be;
        wdata_out <= d;
        wr_out    <= w;
        rd_out    <= !w;
        @(posedge clk_in);
        wr_out    <= 1'h0;
        rd_out    <= 1'h0;
        wdata_out <= ~d;
        #1;
        ack = ack_in;
        q   = rdata_in;
    endtask
endmodule // bdc_host_model

/* File: dv/bdc_regs_tb_top.sv */
// Self-checking bench for the bridge control register bank.
`timescale 1ns/1ps
module bdc_regs_tb_top;
    import bdc_pkg::*;
    logic        core_clk_in, rstn_in, c_func, c_wr, c_rd, c_ack;
    logic [5:0]  c_dw;
    logic [3:0]  c_be;
    logic [31:0] c_wdata, c_rdata;
    logic [1:0]  pwr_req, d3, csc_en, pwr_dn, irq_sel, route, spk, io16, ina;
    logic [1:0][3:0] csc_sel;
    logic        lv_cap, dio, short, nand_en, dt_dis, async_irq;
    logic [7:0]  retry;
    logic [15:0] cb_disc, hb_disc;
    int          n_errors, cmp_count;

    bdc_regs bdc_regs_inst (
        .core_clk_in(core_clk_in), .rstn_in(rstn_in),
        .cfg_func_in(c_func), .cfg_dw_in(c_dw), .cfg_be_in(c_be),
        .cfg_wr_in(c_wr), .cfg_rd_in(c_rd), .cfg_wdata_in(c_wdata),
        .cfg_rdata_out(c_rdata), .cfg_ack_out(c_ack),
        .pwr_down_req_in(pwr_req), .d3_state_in(d3),
        .legacy_csc_en_in(csc_en), .legacy_csc_sel_in(csc_sel),
        .socket_power_down_out(pwr_dn), .low_voltage_capable_out(lv_cap),
        .diagnostic_field_io_bit_out(dio), .interrog_short_out(short),
        .irq_signalling_select_out(irq_sel), .nand_tree_en_out(nand_en),
        .card_status_change_route_out(route),
        .delayed_txn_disable_out(dt_dis), .retry_latency_limit_out(retry),
        .card_bus_discard_limit_out(cb_disc),
        .host_bus_discard_limit_out(hb_disc),
        .async_status_change_irq_out(async_irq),
        .dma_req_speaker_out(spk), .dma_req_io16_out(io16),
        .dma_req_inack_out(ina)
    );

    bdc_host_model bdc_host_model_inst (
        .clk_in(core_clk_in), .ack_in(c_ack), .rdata_in(c_rdata),
        .func_out(c_func), .dw_out(c_dw), .be_out(c_be), .wr_out(c_wr),
        .rd_out(c_rd), .wdata_out(c_wdata)
    );

    initial begin
        core_clk_in = 1'h0;
        forever #5 core_clk_in = ~core_clk_in;
    end

    // ========================================================
    // Checking
    task automatic check(input string what, input logic [63:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic xfer(input logic w, input logic f, input logic [5:0] dw,
                        input logic [3:0] be, input logic [31:0] d);
        logic        a;
        logic [31:0] q;
        bdc_host_model_inst.access(w, f, dw, be, d, a, q);
        check("ack", {63'h0, a}, 64'h1);
        if (!w) check($sformatf("rdata dw %h", dw), {32'h0, q}, {32'h0, d});
    endtask

    task automatic settle();
        @(posedge core_clk_in);
        #1;
    endtask

    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    initial begin
        repeat (5000) @(posedge core_clk_in);
        n_errors++;
        close_out();
    end

    // ========================================================
    // Tests
    initial begin
        n_errors = 0;
        cmp_count = 0;
        rstn_in = 1'h0;
        pwr_req = 2'h0;
        d3 = 2'h0;
        csc_en = 2'h0;
        csc_sel = '0;
        repeat (20) @(posedge core_clk_in);
        rstn_in <= 1'h1;
        xfer(0, 0, 6'h24, 4'hF, 32'h6166_0000);
        xfer(0, 1, 6'h25, 4'hF, 32'h0000_0000);
        check("dc outs", {lv_cap, dio, short, irq_sel, nand_en}, 6'h36);
        check("dg outs", {dt_dis, retry, cb_disc, hb_disc, async_irq},
              {1'h0, 8'h10, 16'h8000, 16'h8000, 1'h1});
        $display("test reset values done");
        // Lane 3 and lanes 0-1 carry ones but are not enabled.
        xfer(1, 0, 6'h24, 4'h4, 32'hFFFF_FFFF);
        xfer(0, 0, 6'h24, 4'hF, 32'h61EF_0000);
        check("dc outs", {lv_cap, dio, short, irq_sel, nand_en}, 6'h3F);
        @(posedge core_clk_in);
        pwr_req <= 2'h3;
        d3 <= 2'h1;
        settle();
        check("power down", pwr_dn, 2'h2);
        xfer(1, 0, 6'h24, 4'h4, 32'h0000_0000);
        check("dc outs", {lv_cap, dio, short, irq_sel, nand_en}, 6'h00);
        check("power down", pwr_dn, 2'h3);
        for (int m = 0; m < 4; m++) begin
            xfer(1, 0, 6'h24, 4'h4, {8'h00, 5'h00, m[1:0], 17'h0});
            check("irq mode", irq_sel, m[1:0]);
        end
        $display("test device control done");
        xfer(1, 0, 6'h24, 4'h8, 32'h9E00_0000);
        check("dg outs", {dt_dis, retry, cb_disc, hb_disc, async_irq},
              {1'h1, 8'h40, 16'h0400, 16'h0400, 1'h0});
        xfer(0, 1, 6'h00, 4'hF, 32'hFFFF_FFFF);
        xfer(1, 0, 6'h24, 4'h8, 32'h0400_0000);
        check("dg outs", {dt_dis, retry, cb_disc, hb_disc, async_irq},
              {1'h0, 8'h10, 16'h0400, 16'h8000, 1'h0});
        xfer(0, 0, 6'h00, 4'hF, BDC_ID_DEFAULT);
        @(posedge core_clk_in);
        csc_en <= 2'h2;
        csc_sel <= {4'h5, 4'h0};
        settle();
        check("csc route", route, 2'h2);
        xfer(1, 0, 6'h24, 4'h8, 32'h2000_0000);
        check("csc route", route, 2'h1);
        $display("test diagnostic done");
        for (int c = 0; c < 4; c++) begin
            xfer(1, 0, 6'h25, 4'hF, {30'h3FFF_FFFF, c[1:0]});
            xfer(0, 0, 6'h25, 4'hF, {30'h0, c[1:0]});
            check("dma outs", {spk, io16, ina}, {1'h0, c == 1, 1'h0,
                  c == 2, 1'h0, c == 3});
        end
        xfer(1, 1, 6'h25, 4'hE, 32'hFFFF_FFFE);
        xfer(0, 1, 6'h25, 4'hF, 32'h0000_0000);
        xfer(1, 1, 6'h25, 4'h1, 32'h0000_0002);
        check("dma outs", {spk, io16, ina}, 6'h09);
        xfer(1, 0, 6'h30, 4'hF, 32'hFFFF_FFFF);
        xfer(0, 0, 6'h30, 4'hF, 32'h0000_0000);
        $display("test socket dma done");
        @(posedge core_clk_in);
        rstn_in <= 1'h0;
        repeat (2) @(posedge core_clk_in);
        rstn_in <= 1'h1;
        xfer(0, 0, 6'h24, 4'hF, 32'h6166_0000);
        xfer(0, 1, 6'h25, 4'hF, 32'h0000_0000);
        check("dma outs", {spk, io16, ina}, 6'h00);
        $display("test second reset done");
        close_out();
    end
endmodule // bdc_regs_tb_top
